/* hdl/asc_pkg.sv */
// Constants, types and helpers of the converter scan auxiliary control.
// Assumes a 100 MHz system clock and a word-aligned Avalon-MM register port.
`default_nettype none
package asc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SETTLE_UNIT_NS  = 1280;
    localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_HOLD_CYC  = 2;
    localparam int WAKE_PIN_CYC    = 2;
    localparam int WAKE_POR_CYC    = 262144;
    localparam int OSC_START_CYC   = 1000;

    // Register byte offsets
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_CMD    = 5'h04;
    localparam logic [4:0] ADDR_DIR    = 5'h08;
    localparam logic [4:0] ADDR_LEVEL  = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;

    // Field positions and reset values
    localparam int         CMD_PULSE_BIT = 0;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] DIR_RST       = 8'hFF;
    localparam logic [7:0] LEVEL_RST     = 8'h00;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       run;
        logic       bias_high;
        logic       bias_en;
        logic       chop_en;
        logic       auto_scan;
        logic [2:0] settle_wait_select;
    } asc_ctrl_s;

    // Status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [3:0] channel;
        logic       chop_phase;
        logic       busy;
        logic       powered_down;
        logic       ready;
    } asc_status_s;

    // Converted result
    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } asc_result_s;

    typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_CONV} asc_state_e;

    // Settle delay in units of the settle period
    function automatic logic [5:0] settle_units(input logic [2:0] sel);
        case (sel)
            3'h0:    settle_units = 6'h00;
            3'h1:    settle_units = 6'h01;
            3'h2:    settle_units = 6'h02;
            3'h3:    settle_units = 6'h04;
            3'h4:    settle_units = 6'h08;
            3'h5:    settle_units = 6'h10;
            3'h6:    settle_units = 6'h20;
            default: settle_units = 6'h30;
        endcase
    endfunction

    // Mean of two signed readings
    function automatic logic [15:0] chop_avg(input logic [15:0] a, input logic [15:0] b);
        logic signed [16:0] sum;
        sum      = $signed({a[15], a}) + $signed({b[15], b});
        chop_avg = sum[16:1];
    endfunction
endpackage
`default_nettype wire

/* hdl/asc_scan_aux.sv */
// Scan sequencing, sensor bias, chopping, general port and power-down control.
// Assumes a converter core that starts on CONV_START_O and answers with CONV_DONE_I.
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`default_nettype none
// Functional notes
// - Delay codes 0..7 select 0,1,2,4,8,16,32,48 units of 128 clocks.
// - Auto scan waits the settle delay after each channel change before converting.
// - Pulse mode converts one channel per start pulse or pulse command.
// - Bias enabled sources current into positive and sinks from negative mux output.
// - Bias reaches only the selected pair through the mux outputs.
// - Chopping takes two opposite-polarity readings and outputs their average.
// - Chopping halves the result rate.
// - Eight port pins, each direction set by its own direction bit.
// - Reading the level register returns actual pin levels.
// - Writing the level register stores output values, even for input pins.
// - Port keeps working and driving outputs during standby and power-down; direction and level writes are ignored while powered down.
// - After reset all port pins are inputs.
// - Power-down engages after sleep pin low two clocks; clock output stops.
// - Registers keep their contents through power-down.
// - External clock: ready 2 clocks after wake, 2^18 after power-up.
// - Internal oscillator: wake covers start-up, plus 2^18 after power-up.
// - Clock output is invalid during the wake interval.
// - Outputs stay driven in power-down; inputs are driven by the system.
module asc_scan_aux
    import asc_pkg::*;
#(
    parameter int WAKE_POR    = WAKE_POR_CYC,
    parameter int OSC_START   = OSC_START_CYC,
    parameter int SETTLE_UNIT = SETTLE_UNIT_CYC
) (
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    // Register port
    input  wire logic [4:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic      [31:0] AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    // Device pins
    input  wire logic        START_I,
    input  wire logic        SLEEP_PIN_N_I,
    input  wire logic        CLOCK_SOURCE_PIN_I,
    output logic             CLOCK_PIN_IO_VALID_O,
    output logic             POWERED_DOWN_O,
    output logic             READY_O,
    // Converter core
    output logic             CONV_START_O,
    input  wire logic        CONV_DONE_I,
    input  wire logic [15:0] CONV_DATA_I,
    output logic             POLARITY_SWAP_O,
    output logic      [3:0]  CHANNEL_O,
    output logic      [15:0] RESULT_O,
    output logic             RESULT_VALID_O,
    // Sensor bias
    output logic             MUX_OUT_POSITIVE_SRC_O,
    output logic             MUX_OUT_NEGATIVE_SNK_O,
    output logic             SENSOR_BIAS_CURRENT_HI_O,
    // General port
    input  wire logic [7:0]  GENERAL_PORT_PINS_I,
    output logic      [7:0]  GENERAL_PORT_PINS_O,
    output logic      [7:0]  GENERAL_PORT_PINS_OE_O
);
    logic        rst_s1;
    logic        rst_n;
    logic        ack;
    asc_ctrl_s   ctrl;
    logic [7:0]  port_direction_reg;
    logic [7:0]  port_level_reg;
    logic [1:0]  sleep_cnt;
    logic        pd;
    logic        por_load;
    logic [19:0] wake_cnt;
    logic        start_q;
    asc_state_e  state;
    logic [12:0] settle_cnt;
    logic        phase;
    logic [15:0] first_read;
    logic [3:0]  channel;
    asc_result_s result;
    logic [12:0] settle_seen;
    logic [12:0] settle_goal;
    logic [1:0]  start_cnt;

    function automatic logic [12:0] settle_cycles(input logic [2:0] sel);
        settle_cycles = 13'(int'(settle_units(sel)) * SETTLE_UNIT);
    endfunction

    // Reset release
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_s1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n  <= rst_s1;
        end
    end

    // Bus decode
    wire        req      = AVS_READ_I | AVS_WRITE_I;
    wire        wr_take  = AVS_WRITE_I & ack & ~pd & AVS_BYTEENABLE_I[0];
    wire        wr_ctrl  = wr_take & (AVS_ADDRESS_I == ADDR_CTRL);
    wire        wr_dir   = wr_take & (AVS_ADDRESS_I == ADDR_DIR);
    wire        wr_level = wr_take & (AVS_ADDRESS_I == ADDR_LEVEL);
    wire        cmd_pulse = wr_take & (AVS_ADDRESS_I == ADDR_CMD)
                            & AVS_WRITEDATA_I[CMD_PULSE_BIT];
    wire asc_status_s status = '{channel: channel, chop_phase: phase,
                                 busy: state != ST_IDLE, powered_down: pd,
                                 ready: READY_O};
    wire [7:0]  rd_byte  = (AVS_ADDRESS_I == ADDR_CTRL)   ? ctrl :
                           (AVS_ADDRESS_I == ADDR_DIR)    ? port_direction_reg :
                           (AVS_ADDRESS_I == ADDR_LEVEL)  ? GENERAL_PORT_PINS_I :
                           (AVS_ADDRESS_I == ADDR_STATUS) ? status : 8'h00;

    assign AVS_WAITREQUEST_O = req & ~ack;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ack            <= 1'b0;
            AVS_READDATA_O <= 32'h00000000;
        end else begin
            ack <= req & ~ack;
            if (AVS_READ_I && !ack) begin
                AVS_READDATA_O <= {24'h000000, rd_byte};
            end
        end
    end

    // Registers, frozen while powered down
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ctrl               <= CTRL_RST;
            port_direction_reg <= DIR_RST;
            port_level_reg     <= LEVEL_RST;
        end else begin
            if (wr_ctrl) ctrl <= AVS_WRITEDATA_I[7:0];
            if (wr_dir) port_direction_reg <= AVS_WRITEDATA_I[7:0];
            if (wr_level) port_level_reg <= AVS_WRITEDATA_I[7:0];
        end
    end

    // General port stays live in power-down
    assign GENERAL_PORT_PINS_O    = port_level_reg;
    assign GENERAL_PORT_PINS_OE_O = ~port_direction_reg;

    // Sensor bias through the selected mux outputs only
    assign MUX_OUT_POSITIVE_SRC_O   = ctrl.bias_en & ~pd;
    assign MUX_OUT_NEGATIVE_SNK_O   = ctrl.bias_en & ~pd;
    assign SENSOR_BIAS_CURRENT_HI_O = ctrl.bias_high;

    // Power-down and wake timing
    wire [19:0] wake_pin = CLOCK_SOURCE_PIN_I ? 20'(WAKE_PIN_CYC) : 20'(OSC_START);
    wire [19:0] wake_por = CLOCK_SOURCE_PIN_I ? 20'(WAKE_POR) : 20'(WAKE_POR + OSC_START);

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            sleep_cnt <= 2'h0;
            pd        <= 1'b0;
            por_load  <= 1'b1;
            wake_cnt  <= 20'h00000;
        end else begin
            sleep_cnt <= SLEEP_PIN_N_I ? 2'h0 : (sleep_cnt == 2'h2 ? 2'h2 : sleep_cnt + 2'h1);
            if (!SLEEP_PIN_N_I && sleep_cnt == 2'(SLEEP_HOLD_CYC - 1)) begin
                pd <= 1'b1;
            end else if (SLEEP_PIN_N_I && pd) begin
                pd       <= 1'b0;
                wake_cnt <= wake_pin;
            end else if (por_load) begin
                por_load <= 1'b0;
                wake_cnt <= wake_por;
            end else if (wake_cnt != 20'h00000) begin
                wake_cnt <= wake_cnt - 20'h00001;
            end
        end
    end

    assign POWERED_DOWN_O       = pd;
    assign READY_O              = ~pd & ~por_load & (wake_cnt == 20'h00000);
    assign CLOCK_PIN_IO_VALID_O = READY_O;

    // Conversion sequencing
    wire        start_rise  = START_I & ~start_q;
    wire        keep_scan   = ctrl.run | START_I;
    wire        trigger     = READY_O & (ctrl.auto_scan ? keep_scan : (start_rise | cmd_pulse));
    wire [12:0] settle_full = settle_cycles(ctrl.settle_wait_select);
    wire        second      = ctrl.chop_en & ~phase;
    wire        again       = ctrl.auto_scan & keep_scan;
    wire        load_settle = (state == ST_IDLE && trigger)
                              || (state == ST_CONV && CONV_DONE_I && (second || again));
    wire [12:0] load_val    = (state == ST_IDLE && !ctrl.auto_scan) ? 13'h0000 : settle_full;

    assign CONV_START_O    = READY_O & (state == ST_SETTLE) & (settle_cnt == 13'h0000);
    assign POLARITY_SWAP_O = phase;
    assign CHANNEL_O       = channel;
    assign RESULT_O        = result.data;
    assign RESULT_VALID_O  = result.valid;

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            start_q <= 1'b0;
            state   <= ST_IDLE;
            phase   <= 1'b0;
            channel <= 4'h0;
            first_read <= 16'h0000;
            result  <= '0;
        end else begin
            start_q      <= START_I;
            result.valid <= 1'b0;
            if (!READY_O) begin
                state <= ST_IDLE;
                phase <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (trigger) state <= ST_SETTLE;
                    end
                    ST_SETTLE: begin
                        if (settle_cnt == 13'h0000) state <= ST_CONV;
                    end
                    ST_CONV: begin
                        if (CONV_DONE_I && second) begin
                            first_read <= CONV_DATA_I;
                            phase      <= 1'b1;
                            state      <= ST_SETTLE;
                        end else if (CONV_DONE_I) begin
                            result.data  <= phase ? chop_avg(first_read, CONV_DATA_I)
                                                  : CONV_DATA_I;
                            result.valid <= 1'b1;
                            phase        <= 1'b0;
                            if (again) begin
                                channel <= channel + 4'h1;
                                state   <= ST_SETTLE;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 13'h0000;
        end else if (load_settle) begin
            settle_cnt <= load_val;
        end else if (state == ST_SETTLE && settle_cnt != 13'h0000) begin
            settle_cnt <= settle_cnt - 13'h0001;
        end
    end

    // Helpers for the checks below
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            settle_seen <= 13'h0000;
            settle_goal <= 13'h0000;
            start_cnt   <= 2'h0;
        end else begin
            settle_seen <= (state == ST_SETTLE) ? settle_seen + 13'h0001 : 13'h0000;
            if (load_settle) settle_goal <= load_val;
            if (RESULT_VALID_O) start_cnt <= {1'b0, CONV_START_O};
            else if (CONV_START_O && start_cnt != 2'h3) start_cnt <= start_cnt + 2'h1;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    sequence s_sleep_low;
        !SLEEP_PIN_N_I [*2];
    endsequence

    a_delay_decode: assert property (
        (state == ST_CONV && CONV_DONE_I && ctrl.auto_scan && keep_scan && READY_O)
        |=> settle_cnt == settle_cycles($past(ctrl.settle_wait_select)))
        else $error("settle count does not match delay code");

    a_settle_span: assert property (
        CONV_START_O |-> settle_seen == settle_goal)
        else $error("conversion started before settle delay ran out");

    a_pulse_single: assert property (
        (RESULT_VALID_O && !ctrl.auto_scan && !$past(ctrl.auto_scan) && state != ST_CONV)
        |-> state == ST_IDLE)
        else $error("pulse mode went on converting");

    a_bias_pair: assert property (
        MUX_OUT_POSITIVE_SRC_O == MUX_OUT_NEGATIVE_SNK_O
        && MUX_OUT_POSITIVE_SRC_O == (ctrl.bias_en && !pd))
        else $error("bias source and sink disagree");

    a_chop_average: assert property (
        (state == ST_CONV && CONV_DONE_I && phase && READY_O)
        |=> RESULT_VALID_O && RESULT_O == chop_avg($past(first_read), $past(CONV_DATA_I)))
        else $error("chopped result is not the mean of both phases");

    a_chop_rate: assert property (
        (state == ST_CONV && CONV_DONE_I && phase && READY_O) |-> start_cnt == 2'h2)
        else $error("chopped result did not take two conversions");

    a_port_dir: assert property (
        GENERAL_PORT_PINS_OE_O == ~port_direction_reg
        && GENERAL_PORT_PINS_O == port_level_reg)
        else $error("port pins do not follow direction and level");

    a_port_read: assert property (
        (AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I == ADDR_LEVEL)
        |=> AVS_READDATA_O == {24'h000000, $past(GENERAL_PORT_PINS_I)})
        else $error("level read does not return pin levels");

    a_sleep_engage: assert property (
        (s_sleep_low ##1 !SLEEP_PIN_N_I) |-> POWERED_DOWN_O)
        else $error("power-down did not engage after two low clocks");

    a_sleep_hold: assert property (
        $rose(POWERED_DOWN_O) |-> !$past(SLEEP_PIN_N_I) && !$past(SLEEP_PIN_N_I, 2))
        else $error("power-down engaged too early");

    a_retain_regs: assert property (
        POWERED_DOWN_O |=> $stable(ctrl) && $stable(port_level_reg))
        else $error("register changed during power-down");

    a_wake_ext: assert property (
        ($fell(POWERED_DOWN_O) && CLOCK_SOURCE_PIN_I)
        |-> !READY_O ##1 !READY_O ##1 (READY_O || POWERED_DOWN_O))
        else $error("external clock wake time wrong");

    a_clock_valid: assert property (
        CLOCK_PIN_IO_VALID_O |-> READY_O && !POWERED_DOWN_O)
        else $error("clock output valid during wake interval");
endmodule
`default_nettype wire

/* test/asc_core_model.sv */
// Converter core stand-in that answers each start after a set latency.
// Assumes one request at a time; the offset changes sign when the inputs are swapped.
`default_nettype none
module asc_core_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Request and answer
    input  wire logic        start_i,
    input  wire logic        pol_i,
    input  wire logic [3:0]  lat_i,
    input  wire logic [15:0] sig_i,
    input  wire logic [15:0] off_i,
    output logic             done_o,
    output logic      [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 4'h0;
            done_o <= 1'b0;
            data_o <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            // Data outside the answer cycle changes every cycle
            data_o <= ~data_o;
            if (start_i) begin
                cnt <= lat_i;
            end else if (cnt == 4'h1) begin
                cnt <= 4'h0;
                done_o <= 1'b1;
                data_o <= pol_i ? sig_i - off_i : sig_i + off_i;
            end else if (cnt > 4'h1) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* test/tb_asc_scan_aux.sv */
// Self-checking bench of the scan auxiliary control.
// Assumes the core stand-in and a 100 MHz clock; counts are shortened by parameters.
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_asc_scan_aux
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WAKE_T = 20;
    localparam int OSC_T  = 5;
    localparam int SU     = 4;
    int units [8] = '{0, 1, 2, 4, 8, 16, 32, 48};
    int bad_count = 0;
    int checks = 0;
    int starts = 0;
    int n, n0, gap;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic        sleep_n = 1'b1;
    logic        start = 1'b0;
    logic        clk_src = 1'b1;
    logic [15:0] sig = 16'h0000;
    logic [15:0] off = 16'h0000;
    logic [3:0]  lat = 4'h1;
    logic [7:0]  ext = 8'h00;
    logic [15:0] seed = 16'h0008;
    logic [31:0] q;
    logic [7:0]  d, l, ch;
    logic [31:0] rdata;
    logic        wait_req, clk_ok, pd, ready, conv_start, conv_done, pol, res_valid;
    logic        src, snk, hi;
    logic [15:0] conv_data, result;
    logic [3:0]  chan;
    logic [7:0]  pout, poe;
    // Pad level: driven by the port where enabled, else by the system
    wire logic [7:0] pad = (poe & pout) | (~poe & ext);

    always #5 clk = ~clk;
    always @(posedge clk) if (conv_start === 1'b1) starts++;

    asc_scan_aux #(.WAKE_POR(WAKE_T), .OSC_START(OSC_T), .SETTLE_UNIT(SU)) dut (
        .CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
        .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .START_I(start),
        .SLEEP_PIN_N_I(sleep_n), .CLOCK_SOURCE_PIN_I(clk_src),
        .CLOCK_PIN_IO_VALID_O(clk_ok), .POWERED_DOWN_O(pd), .READY_O(ready),
        .CONV_START_O(conv_start), .CONV_DONE_I(conv_done), .CONV_DATA_I(conv_data),
        .POLARITY_SWAP_O(pol), .CHANNEL_O(chan), .RESULT_O(result),
        .RESULT_VALID_O(res_valid), .MUX_OUT_POSITIVE_SRC_O(src),
        .MUX_OUT_NEGATIVE_SNK_O(snk), .SENSOR_BIAS_CURRENT_HI_O(hi),
        .GENERAL_PORT_PINS_I(pad), .GENERAL_PORT_PINS_O(pout), .GENERAL_PORT_PINS_OE_O(poe));

    asc_core_model core (.clk_i(clk), .rst_n_i(rst_n), .start_i(conv_start), .pol_i(pol),
        .lat_i(lat), .sig_i(sig), .off_i(off), .done_o(conv_done), .data_o(conv_data));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic rnd();
        seed = lfsr(seed);
        sig <= {seed[14], seed[14:0]};
        off <= {8'h00, seed[7:0]};
        lat <= {2'b00, seed[9:8]} + 4'h1;
    endtask

    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= !w;
        wr <= w;
        wdata <= {24'h0, v};
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wait_start();
        n = 0;
        do begin @(negedge clk); n++; end while (conv_start !== 1'b1);
    endtask

    task automatic wait_done();
        do @(negedge clk); while (conv_done !== 1'b1);
    endtask

    task automatic wait_res();
        do @(negedge clk); while (res_valid !== 1'b1);
    endtask

    task automatic wait_ready();
        n = 0;
        do begin @(negedge clk); n++; end while (ready !== 1'b1);
    endtask

    task automatic results();
        if (bad_count == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        `CHK("oe_rst", 8'h00, poe)
        wait_ready();
        `CHK("por_wake", 1'b1, n >= WAKE_T && n <= WAKE_T + 6)
        `CHK("clk_valid", 1'b1, clk_ok)
        bus(0, ADDR_STATUS, 8'h00);
        `CHK("status_rd", 32'h01, q)
        bus(0, ADDR_DIR, 8'h00);
        `CHK("dir_rst", 32'hFF, q)
        bus(1, 5'h14, 8'h5A);
        bus(0, 5'h14, 8'h00);
        `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < 5; i++) begin
            rnd();
            ext <= seed[15:8];
            l = seed[7:0];
            d = (i == 0) ? 8'h00 : seed[11:4];
            bus(1, ADDR_LEVEL, l);
            bus(1, ADDR_DIR, d);
            @(negedge clk);
            `CHK("port_oe", ~d, poe)
            `CHK("port_out", l, pout)
            bus(0, ADDR_LEVEL, 8'h00);
            `CHK("port_pins", {24'h0, (~d & l) | (d & ext)}, q)
        end
        bus(1, ADDR_CTRL, 8'h60);
        @(negedge clk);
        `CHK("bias_src", 1'b1, src)
        `CHK("bias_snk", 1'b1, snk)
        `CHK("bias_hi", 1'b1, hi)
        bus(1, ADDR_CTRL, 8'h20);
        bus(0, ADDR_CTRL, 8'h00);
        `CHK("ctrl_rd", 32'h20, q)
        `CHK("bias_lo", 1'b0, hi)
        bus(1, ADDR_CTRL, 8'h00);
        @(negedge clk);
        `CHK("bias_off", 1'b0, src)
        rnd();
        n0 = starts;
        bus(1, ADDR_CMD, 8'h01);
        wait_res();
        `CHK("pulse_res", sig + off, result)
        repeat (30) @(posedge clk);
        `CHK("one_conv", n0 + 1, starts)
        start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        wait_res();
        `CHK("pin_res", sig + off, result)
        repeat (30) @(posedge clk);
        `CHK("pin_conv", n0 + 2, starts)
        for (int k = 0; k < 8; k++) begin
            rnd();
            bus(1, ADDR_CTRL, 8'h10 | k[7:0]);
            n0 = starts;
            gap = units[k] * SU;
            bus(1, ADDR_CMD, 8'h01);
            wait_start();
            `CHK("phase0", 1'b0, pol)
            wait_done();
            wait_start();
            `CHK("settle_gap", 1'b1, n > gap && n <= gap + 4)
            `CHK("phase1", 1'b1, pol)
            wait_res();
            `CHK("chop_mean", sig, result)
            `CHK("two_reads", n0 + 2, starts)
        end
        bus(1, ADDR_CTRL, 8'h8A);
        wait_start();
        for (int i = 0; i < 3; i++) begin
            ch = {4'h0, chan};
            wait_done();
            wait_start();
            `CHK("scan_gap", 1'b1, n > 2 * SU && n <= 2 * SU + 4)
            `CHK("scan_chan", ch[3:0] + 4'h1, chan)
        end
        bus(1, ADDR_CTRL, 8'h00);
        repeat (20) @(posedge clk);
        bus(1, ADDR_DIR, 8'h0F);
        bus(1, ADDR_LEVEL, 8'hA5);
        @(posedge clk) sleep_n <= 1'b0;
        @(posedge clk) sleep_n <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK("pd_short", 1'b0, pd)
        for (int s = 0; s < 2; s++) begin
            @(posedge clk) sleep_n <= 1'b0;
            repeat (3) @(negedge clk);
            `CHK("pd_on", 1'b1, pd)
            `CHK("pd_clk", 1'b0, clk_ok)
            `CHK("pd_out", 8'hA5, pout)
            `CHK("pd_oe", 8'hF0, poe)
            bus(1, ADDR_DIR, 8'hFF);
            bus(0, ADDR_LEVEL, 8'h00);
            `CHK("pd_pins", {24'h0, 8'hA0 | (ext & 8'h0F)}, q)
            @(posedge clk) sleep_n <= 1'b1;
            wait_ready();
            if (s == 0) `CHK("wake_ext", 1'b1, n >= 2 && n <= 6)
            else `CHK("wake_osc", 1'b1, n >= OSC_T && n <= OSC_T + 5)
            bus(0, ADDR_DIR, 8'h00);
            `CHK("pd_keep", 32'h0F, q)
            clk_src <= 1'b0;
        end
        results();
    end
endmodule
`default_nettype wire
